// >>> src/cfg_spi_pkg.sv
// constants and carrier types of the chained configuration serial port
//
// How it works
// - input reaches output 24 clocks later
// - chain length field, bits 6..2, count minus one
// - read command preloads output stage at frame end
// - next frame shifts out address then value
// - control bit 2 picks chained or single mode
// - control bit 1 enables reads, single mode only
// - control bit 0 resets all registers
// - last control word readable through mirror at 06h; mirror reads 0002h after reset
// - bank select 0, 2, 16 route later accesses
// - 16-bit registers, 8-bit address, 24-bit frame
// - bank 0 addresses decoded whatever the bank
`default_nettype none
package cfg_spi_pkg;
  localparam int WORD_BITS = 24;
  localparam logic [4:0] LAST_BIT = 5'h17;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHAIN = 8'h01;
  localparam logic [7:0] ADDR_BANK = 8'h03;
  localparam logic [7:0] ADDR_INIT = 8'h04;
  localparam logic [7:0] ADDR_MIRROR = 8'h06;
  localparam logic [7:0] CMD_READ = 8'hFE;
  localparam logic [7:0] CMD_FILL = 8'hFF;
  localparam int CTRL_SOFT_RESET = 0;
  localparam int CTRL_READ_EN = 1;
  localparam int CTRL_SINGLE = 2;
  localparam int CHAIN_HI = 6;
  localparam int CHAIN_LO = 2;
  localparam int KEY_HI = 3;
  localparam logic [7:0] BANK_CODE_0 = 8'h00;
  localparam logic [7:0] BANK_CODE_1 = 8'h02;
  localparam logic [7:0] BANK_CODE_2 = 8'h10;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_CHAIN = 16'h0000;
  localparam logic [15:0] RST_BANK = 16'h0002;
  localparam logic [15:0] RST_INIT = 16'h0000;
  localparam logic [15:0] RST_MIRROR = 16'h0002;
  localparam logic [1:0] ROUTE_BANK0 = 2'h0;
  localparam logic [1:0] ROUTE_BANK1 = 2'h1;
  localparam logic [1:0] ROUTE_BANK2 = 2'h2;
  localparam logic [1:0] ROUTE_NONE = 2'h3;

  typedef struct packed {
    logic [23:0] load_word;
    logic load_en;
  } link_in_t;

  typedef struct packed {
    logic [23:0] word;
    logic [4:0] cnt;
    logic done;
  } link_out_t;

  typedef struct packed {
    logic [23:0] shift;
    logic [4:0] cnt;
    logic done;
  } link_state_t;

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic single;
    logic rd_en;
    logic [15:0] chain;
    logic [15:0] bank;
    logic [15:0] init;
    logic [15:0] mirror;
    logic [23:0] load_word;
    logic load_en;
    logic conv_reset;
    logic reject;
    logic flush;
  } port_state_t;
endpackage
`default_nettype wire

// >>> src/cfg_spi_port.sv
// chained configuration serial port: frame decode and bank 0 registers
`default_nettype none
module cfg_spi_port (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDI,
  output logic SDO,
  output logic CONV_RESET,
  output logic SINGLE_MODE,
  output logic READ_ENABLE,
  output logic [4:0] CHAIN_LENGTH,
  output logic [1:0] BANK_ROUTE,
  output logic [3:0] INIT_KEY,
  output logic FRAME_REJECT
);
  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial-clock domain

  cfg_spi_pkg::port_state_t st;
  cfg_spi_pkg::port_state_t next_st;
  cfg_spi_pkg::link_in_t link_in;
  cfg_spi_pkg::link_out_t link_out;
  logic stage_rst_n;

  // stage is wiped one cycle after decode; needs select high 4 cycles
  assign stage_rst_n = rst_n & ~st.flush;

  // load word and enable only change while deselected, so the link
  // sees them settled long before its first edge of the next frame
  assign link_in = '{load_word: st.load_word, load_en: st.load_en};

  chain_shift_stage u_stage (
    .sclk(SCLK),
    .cs_n(CS_N),
    .rst_n(stage_rst_n),
    .sdi(SDI),
    .load(link_in),
    .sdo(SDO),
    .stat(link_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame decode

  logic frame_end;
  logic frame_ok;
  logic [7:0] cmd;
  logic [15:0] payload;
  logic is_read;
  logic wr_en;
  logic [7:0] rd_addr;

  // link word is frozen once select is high; sampled after two flops
  assign frame_end = st.cs_sync && !st.cs_prev;
  assign frame_ok = link_out.done && (link_out.cnt == 5'h00);
  assign cmd = link_out.word[23:16];
  assign payload = link_out.word[15:0];

  always_comb
  begin
    is_read = 1'b0;
    wr_en = 1'b0;
    rd_addr = cmd;
    if (frame_end && frame_ok)
    begin
      if (!st.single)
      begin
        // read-enable is ignored while chained
        if (cmd == cfg_spi_pkg::CMD_READ)
        begin
          is_read = 1'b1;
          rd_addr = link_out.word[7:0];
        end
        else if (cmd != cfg_spi_pkg::CMD_FILL)
        begin
          wr_en = 1'b1;
        end
      end
      else if (st.rd_en && (cmd != cfg_spi_pkg::ADDR_CTRL))
      begin
        // control stays writable so reads can be switched off again
        is_read = 1'b1;
      end
      else
      begin
        wr_en = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read mux

  function automatic logic [15:0] read_reg(input cfg_spi_pkg::port_state_t s,
                                           input logic [7:0] addr);
    logic [15:0] value;
    value = 16'h0000;
    case (addr)
      cfg_spi_pkg::ADDR_CHAIN: value = s.chain;
      cfg_spi_pkg::ADDR_BANK: value = s.bank;
      cfg_spi_pkg::ADDR_INIT: value = s.init;
      cfg_spi_pkg::ADDR_MIRROR: value = s.mirror;
      default: value = 16'h0000;
    endcase
    return value;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state update

  always_comb
  begin
    next_st = st;
    next_st.cs_meta = CS_N;
    next_st.cs_sync = st.cs_meta;
    next_st.cs_prev = st.cs_sync;
    next_st.conv_reset = 1'b0;
    next_st.flush = frame_end;
    next_st.reject = frame_end && !frame_ok && (link_out.done || link_out.cnt != 5'h00);
    if (frame_end)
    begin
      // a preload serves exactly one following frame
      next_st.load_en = 1'b0;
    end
    if (is_read)
    begin
      next_st.load_word = {rd_addr, read_reg(st, rd_addr)};
      next_st.load_en = 1'b1;
    end
    if (wr_en)
    begin
      // bank 0 addresses decode regardless of the bank select
      case (cmd)
        cfg_spi_pkg::ADDR_CTRL:
        begin
          if (payload[cfg_spi_pkg::CTRL_SOFT_RESET])
          begin
            next_st.single = 1'b0;
            next_st.rd_en = 1'b0;
            next_st.chain = cfg_spi_pkg::RST_CHAIN;
            next_st.bank = cfg_spi_pkg::RST_BANK;
            next_st.init = cfg_spi_pkg::RST_INIT;
            next_st.mirror = cfg_spi_pkg::RST_MIRROR;
            next_st.load_en = 1'b0;
            next_st.conv_reset = 1'b1;
          end
          else
          begin
            next_st.single = payload[cfg_spi_pkg::CTRL_SINGLE];
            next_st.rd_en = payload[cfg_spi_pkg::CTRL_READ_EN];
            next_st.mirror = payload;
          end
        end
        cfg_spi_pkg::ADDR_CHAIN: next_st.chain = payload;
        cfg_spi_pkg::ADDR_BANK: next_st.bank = payload;
        cfg_spi_pkg::ADDR_INIT: next_st.init = payload;
        default: next_st.chain = st.chain;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '{cs_meta: 1'b1, cs_sync: 1'b1, cs_prev: 1'b1,
              single: cfg_spi_pkg::RST_CTRL[cfg_spi_pkg::CTRL_SINGLE],
              rd_en: cfg_spi_pkg::RST_CTRL[cfg_spi_pkg::CTRL_READ_EN],
              chain: cfg_spi_pkg::RST_CHAIN, bank: cfg_spi_pkg::RST_BANK,
              init: cfg_spi_pkg::RST_INIT, mirror: cfg_spi_pkg::RST_MIRROR,
              load_word: 24'h000000, load_en: 1'b0, conv_reset: 1'b0,
              reject: 1'b0, flush: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb
  begin
    case (st.bank[7:0])
      cfg_spi_pkg::BANK_CODE_0: BANK_ROUTE = cfg_spi_pkg::ROUTE_BANK0;
      cfg_spi_pkg::BANK_CODE_1: BANK_ROUTE = cfg_spi_pkg::ROUTE_BANK1;
      cfg_spi_pkg::BANK_CODE_2: BANK_ROUTE = cfg_spi_pkg::ROUTE_BANK2;
      default: BANK_ROUTE = cfg_spi_pkg::ROUTE_NONE;
    endcase
  end

  assign CONV_RESET = st.conv_reset;
  assign SINGLE_MODE = st.single;
  assign READ_ENABLE = st.single && st.rd_en;
  assign CHAIN_LENGTH = st.chain[cfg_spi_pkg::CHAIN_HI:cfg_spi_pkg::CHAIN_LO];
  assign INIT_KEY = st.init[cfg_spi_pkg::KEY_HI:0];
  assign FRAME_REJECT = st.reject;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_SOFT_RESET: assert property (@(posedge CLK) disable iff (!rst_n)
    (wr_en && cmd == cfg_spi_pkg::ADDR_CTRL && payload[0])
    |=> (CONV_RESET && st.chain == cfg_spi_pkg::RST_CHAIN && st.bank == cfg_spi_pkg::RST_BANK
         && st.mirror == cfg_spi_pkg::RST_MIRROR && !SINGLE_MODE) ##1 !CONV_RESET)
    else $error("soft reset did not restore defaults");

  AST_MODE_SELECT: assert property (@(posedge CLK) disable iff (!rst_n)
    (wr_en && cmd == cfg_spi_pkg::ADDR_CTRL && !payload[0])
    |=> (SINGLE_MODE == $past(payload[2])))
    else $error("interface mode does not follow control bit 2");

  AST_READ_GATED: assert property (@(posedge CLK) disable iff (!rst_n)
    (frame_end && frame_ok && !st.single && cmd != cfg_spi_pkg::CMD_READ)
    |-> !is_read)
    else $error("chained frame treated as read without read command");

  AST_MIRROR: assert property (@(posedge CLK) disable iff (!rst_n)
    (wr_en && cmd == cfg_spi_pkg::ADDR_CTRL && !payload[0])
    |=> (read_reg(st, cfg_spi_pkg::ADDR_MIRROR) == $past(payload)))
    else $error("mirror does not copy the control word");

  AST_READ_LOAD: assert property (@(posedge CLK) disable iff (!rst_n)
    (frame_end && frame_ok && !st.single && cmd == cfg_spi_pkg::CMD_READ)
    |=> (st.load_en && st.load_word[23:16] == $past(link_out.word[7:0])))
    else $error("read command did not preload the output word");

  AST_BANK_ROUTE: assert property (@(posedge CLK) disable iff (!rst_n)
    (wr_en && cmd == cfg_spi_pkg::ADDR_BANK && payload[7:0] == cfg_spi_pkg::BANK_CODE_2)
    |=> (BANK_ROUTE == cfg_spi_pkg::ROUTE_BANK2) [*2])
    else $error("bank 2 select not routed");

  AST_CHAIN_FIELD: assert property (@(posedge CLK) disable iff (!rst_n)
    (wr_en && cmd == cfg_spi_pkg::ADDR_CHAIN)
    |=> (CHAIN_LENGTH == $past(payload[6:2])))
    else $error("chain length field not taken from bits 6 to 2");

  AST_BANK0_ALWAYS: assert property (@(posedge CLK) disable iff (!rst_n)
    (wr_en && cmd == cfg_spi_pkg::ADDR_INIT && st.bank[7:0] != cfg_spi_pkg::BANK_CODE_0)
    |=> (INIT_KEY == $past(payload[3:0])))
    else $error("bank 0 register not reached under other bank");

  AST_BAD_FRAME: assert property (@(posedge CLK) disable iff (!rst_n)
    (frame_end && !frame_ok)
    |=> ($stable(st.chain) && $stable(st.bank) && $stable(st.init) && $stable(st.mirror) && !st.load_en))
    else $error("partial frame changed registers");

  AST_FRAME_WORD: assert property (@(posedge CLK) disable iff (!rst_n)
    (frame_end && frame_ok && !st.single && cmd != cfg_spi_pkg::CMD_READ
     && cmd != cfg_spi_pkg::CMD_FILL) |-> wr_en)
    else $error("complete chained word not written");
endmodule
`default_nettype wire

// >>> src/chain_shift_stage.sv
// serial-clock side: 24-bit shift stage, bit counter and read preload
`default_nettype none
module chain_shift_stage (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic rst_n,
  input wire logic sdi,
  input wire cfg_spi_pkg::link_in_t load,
  output logic sdo,
  output cfg_spi_pkg::link_out_t stat
);
  cfg_spi_pkg::link_state_t st;
  cfg_spi_pkg::link_state_t next_st;
  logic clear;
  logic first;

  // word must outlive deselect until decode has taken it; decode then
  // pulses rst_n low, so a frame without clock edges finds nothing stale
  assign clear = ~rst_n;
  assign first = (st.cnt == 5'h00) && !st.done;

  always_comb
  begin
    next_st = st;
    // stray edges while deselected would corrupt the waiting word
    if (!cs_n)
    begin
      if (first && load.load_en)
      begin
        next_st.shift = {load.load_word[22:0], sdi};
      end
      else
      begin
        next_st.shift = {st.shift[22:0], sdi};
      end
      if (st.cnt == cfg_spi_pkg::LAST_BIT)
      begin
        next_st.cnt = 5'h00;
        next_st.done = 1'b1;
      end
      else
      begin
        next_st.cnt = st.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge sclk or posedge clear)
  begin
    if (clear)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // first bit of a preloaded word must be out before the first edge
  assign sdo = (first && load.load_en) ? load.load_word[23] : st.shift[23];
  assign stat = '{word: st.shift, cnt: st.cnt, done: st.done};

  AST_DELAY_24: assert property (@(posedge sclk) disable iff (clear)
    (st.done && !load.load_en) |-> (sdo == $past(sdi, 24)))
    else $error("serial output is not input delayed by 24 clocks");
endmodule
`default_nettype wire

// >>> verification/cfg_host_model.sv
// host-side serial master model for the chained configuration port
`default_nettype none
module cfg_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    sclk = 1'h0;
    cs_n = 1'h1;
    sdi = 1'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one frame, msb first, shared select and clock
  // clock stands low between frames; rx bit i is sampled just before its rising edge
  task automatic xfer(input int nbits, input logic [47:0] tx, output logic [47:0] rx);
    rx = '0;
    #13.7;
    cs_n = 1'h0;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      sdi = tx[i];
      #62.5;
      rx[i] = sdo;
      sclk = 1'h1;
      #62.5;
      sclk = 1'h0;
    end
    #62.5;
    cs_n = 1'h1;
    // released line flips so a stale bit is never mistaken for data
    sdi = ~sdi;
    // long gap lets the read preload settle
    #200;
  endtask
endmodule
`default_nettype wire

// >>> verification/config_spi_daisy_chain_tb_top.sv
// self-checking bench for the chained configuration port
`default_nettype none
module config_spi_daisy_chain_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic reset_n;
  logic sclk, cs_n, sdi, sdo;
  logic conv_reset, single_mode, read_enable, frame_reject;
  logic [4:0] chain_length;
  logic [1:0] bank_route;
  logic [3:0] init_key;
  logic [47:0] rx;
  logic [7:0] codes [4] = '{8'h00, 8'h10, 8'h05, 8'h02};
  logic [1:0] routes [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  int failures = 0;
  int checks_done = 0;
  int n_conv = 0;
  int n_rej = 0;

  cfg_spi_port dut_u (
    .CLK(clk),
    .RESET_N(reset_n),
    .SCLK(sclk),
    .CS_N(cs_n),
    .SDI(sdi),
    .SDO(sdo),
    .CONV_RESET(conv_reset),
    .SINGLE_MODE(single_mode),
    .READ_ENABLE(read_enable),
    .CHAIN_LENGTH(chain_length),
    .BANK_ROUTE(bank_route),
    .INIT_KEY(init_key),
    .FRAME_REJECT(frame_reject)
  );

  cfg_host_model host_u (
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .sdo(sdo)
  );

  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // pulses last one cycle, so count them as they pass
  always @(posedge clk)
  begin
    if (conv_reset === 1'h1)
      n_conv++;
    if (frame_reject === 1'h1)
      n_rej++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic st(input logic [12:0] e, input string what);
    check({35'h0, single_mode, read_enable, chain_length, bank_route, init_key}, {35'h0, e}, what);
  endtask

  task automatic wr(input logic [23:0] w);
    host_u.xfer(24, {24'h000000, w}, rx);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] v, input string what);
    wr({8'hFE, 8'h00, a});
    host_u.xfer(24, 48'h000000FFFFFF, rx);
    check(rx, {24'h0, a, v}, what);
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_n = 1'h0;
    repeat (12) @(posedge clk);
    #1 reset_n = 1'h1;
    repeat (4) @(posedge clk);
    st({1'h0, 1'h0, 5'h00, 2'h1, 4'h0}, "reset state");
    $display("test reset done");

    wr(24'h01000C);
    st({1'h0, 1'h0, 5'h03, 2'h1, 4'h0}, "chain length 3");
    wr(24'h01007C);
    st({1'h0, 1'h0, 5'h1F, 2'h1, 4'h0}, "chain length 31");
    wr(24'h010000);
    $display("test chain length done");

    foreach (codes[i])
    begin
      wr({16'h0300, codes[i]});
      st({1'h0, 1'h0, 5'h00, routes[i], 4'h0}, "bank route");
    end
    wr(24'h04000B);
    st({1'h0, 1'h0, 5'h00, 2'h1, 4'hB}, "init key");
    $display("test bank and key done");

    // bank 1 selected, bank 0 still decoded
    wr(24'hFE0003);
    host_u.xfer(48, 48'hA5C3F0FFFFFF, rx);
    check(rx, 48'h030002A5C3F0, "read word then pass-through");
    rd(8'h04, 16'h000B, "read init key");
    rd(8'h06, 16'h0002, "mirror reset");
    $display("test chained read done");

    host_u.xfer(25, 48'h00000101007C, rx);
    check(48'(n_rej), 48'h1, "reject pulse");
    st({1'h0, 1'h0, 5'h00, 2'h1, 4'hB}, "reject no effect");
    $display("test reject done");

    wr(24'h000002);
    st({1'h0, 1'h0, 5'h00, 2'h1, 4'hB}, "read enable chained");
    wr(24'h000006);
    st({1'h1, 1'h1, 5'h00, 2'h1, 4'hB}, "single mode");
    host_u.xfer(24, 48'h000000060000, rx);
    host_u.xfer(24, 48'h000000FFFFFF, rx);
    check(rx, 48'h000000060006, "mirror copy");
    $display("test control done");

    wr(24'h000001);
    check(48'(n_conv), 48'h1, "soft reset pulse");
    st({1'h0, 1'h0, 5'h00, 2'h1, 4'h0}, "soft reset state");
    rd(8'h06, 16'h0002, "mirror after soft reset");
    $display("test soft reset done");
    report_and_stop();
  end

  initial
  begin
    #300000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
